// file: inc/vat_pkg.sv
// constants and types for the virtual address translation walker.
// assumes one clock, and requests and memory answers from logic on that clock.
// Contract
// R1 - page-table entry base is upper 20 bits of a 4096-byte aligned page
// R2 - directory entry base is upper 20 bits of a page-aligned page table
// R3 - invalid entry: bits 1 to 31 are ignored
// R4 - user rights: 00/01 none, 10 read only, 11 read-write
// R5 - supervisor rights: 00 read only, 01/10/11 read-write
// R6 - single-level paged page takes rights from its page-table entry only
// R7 - two-level paged page gets lesser of directory and table rights
// R8 - physical mode bypasses translation and checks; virtual mode checks every access
// R9 - virtual mode translates every operand address before use
// R10 - second-level page tables are one page; size limits only the directory
// R11 - small table: segment index above 255 gives segment-length fault
// R12 - small table descriptor at base plus 16 times index; invalid faults
// R13 - large table: segment index above 262143 gives segment-length fault
// R14 - large table: page table from descriptor 8, entry by selector bits 14-23
// R15 - large table: invalid selected page-table entry faults
// R16 - large table descriptor at entry base plus 16 times bits 6-13
// R17 - address bits 30-31 pick region selector, which locates region descriptor
// R18 - invalid-type region descriptor gives invalid-descriptor fault
// R19 - region descriptor with valid flag zero gives invalid table-entry fault
// R20 - simple region: any of address bits 12-29 set gives length fault
// R21 - set accessed, and altered on writes, written back as locked rmw
// R22 - simple region address is 20-bit base joined with address bits 0-11
// R23 - a fault aborts the access and reports exactly one fault type
package vat_pkg;
    localparam logic [31:0] BASE_MASK = 32'hfffff000;
    localparam logic [31:0] DESC_CTRL_OFS = 32'h0000000c;
    localparam int unsigned DESC_SHIFT = 4;
    localparam int unsigned WORD_SHIFT = 2;
    localparam int unsigned SS_IDX_LSB = 6;
    localparam logic [25:0] SMALL_IDX_MAX = 26'h00000ff;
    localparam logic [25:0] LARGE_IDX_MAX = 26'h003ffff;
    localparam logic [31:0] LARGE_PT_IDX = 32'h00000008;
    localparam int unsigned ENT_VALID_BIT = 0;
    localparam int unsigned ENT_ACC_BIT = 3;
    localparam int unsigned ENT_ALT_BIT = 4;
    localparam int unsigned ENT_RIGHTS_LSB = 6;
    localparam int unsigned DESC_TYPE_LSB = 5;
    localparam logic [2:0] TYPE_INVALID = 3'h0;
    localparam logic [2:0] TYPE_SIMPLE = 3'h1;
    localparam logic [2:0] TYPE_PAGED = 3'h2;
    localparam logic [2:0] TYPE_BIPAGED = 3'h3;
    localparam logic [1:0] RTS_USER_RO = 2'h2;
    localparam logic [1:0] RTS_USER_RW = 2'h3;
    localparam logic [1:0] RTS_SUP_RO = 2'h0;

    typedef enum logic [2:0] {FLT_NONE, FLT_SEG_LEN, FLT_INV_SEG_DESC, FLT_INV_PTE,
        FLT_INV_PDE, FLT_INV_DESC, FLT_INV_STE, FLT_RIGHTS} vat_fault_t;
    typedef enum logic [1:0] {ACC_NONE, ACC_RO, ACC_RW} vat_acc_t;
    typedef enum logic {KIND_XLATE, KIND_LOCATE} vat_kind_t;
    typedef enum logic [2:0] {ST_IDLE, ST_LPT, ST_LPTE, ST_DESC, ST_PDE, ST_PTE, ST_WB} vat_state_t;

    typedef struct packed {
        vat_kind_t kind;
        logic [31:0] addr;
        logic write;
        logic user;
    } vat_req_t;

    typedef struct packed {
        logic [31:0] paddr;
        vat_fault_t fault;
        vat_acc_t rights;
    } vat_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic lock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } vat_mem_req_t;

    typedef struct packed {
        vat_state_t state;
        logic ready;
        vat_req_t req;
        logic [31:0] ss;
        logic [31:0] daddr;
        vat_acc_t lev;
        logic [31:0] wb_pa;
        vat_mem_req_t mem;
        logic rsp_valid;
        vat_rsp_t rsp;
    } vat_st_t;
endpackage

// file: logic/vat_walker.sv
// translation walker: selector lookup, region walk, rights check, flag write-back.
// assumes the pipeline and the memory port run on mclk; one memory access at a time.
`timescale 1ns/1ps
module vat_walker
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic virt_mode,
    input wire logic large_table,
    input wire logic [31:0] st_base,
    input wire logic [3:0][31:0] region_ss,
    input wire logic req_valid,
    input wire vat_pkg::vat_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output vat_pkg::vat_rsp_t rsp,
    output vat_pkg::vat_mem_req_t mem,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    import vat_pkg::*;

    vat_st_t s;
    vat_st_t n;
    logic [31:0] acc_ss;
    logic [25:0] acc_idx;

    // R1 page base
    function automatic logic [31:0] ent_base(logic [31:0] w);
        return w & BASE_MASK;
    endfunction

    function automatic logic [31:0] word_at(logic [31:0] base, logic [31:0] idx);
        return base + (idx << WORD_SHIFT);
    endfunction

    function automatic logic [31:0] desc_at(logic [31:0] base, logic [31:0] idx);
        return base + (idx << DESC_SHIFT);
    endfunction

    // R4 user decode
    // R5 supervisor decode
    function automatic vat_acc_t rights_lev(logic [31:0] w, logic user);
        logic [1:0] r;
        r = w[ENT_RIGHTS_LSB +: 2];
        if (user)
        begin
            return (r == RTS_USER_RW) ? ACC_RW : ((r == RTS_USER_RO) ? ACC_RO : ACC_NONE);
        end
        return (r == RTS_SUP_RO) ? ACC_RO : ACC_RW;
    endfunction

    // R7 lesser rights
    function automatic vat_acc_t min_lev(vat_acc_t a, vat_acc_t b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic denied(vat_acc_t l, logic write);
        return (l == ACC_NONE) || (write && (l == ACC_RO));
    endfunction

    function automatic vat_mem_req_t rd(logic [31:0] a, logic lock);
        vat_mem_req_t m;
        m = '0;
        m.req = 1'b1;
        m.lock = lock;
        m.addr = a;
        return m;
    endfunction

    // R23 single fault report
    function automatic vat_st_t finish(vat_st_t x, logic [31:0] pa, vat_fault_t f, vat_acc_t l);
        vat_st_t y;
        y = x;
        y.state = ST_IDLE;
        y.ready = 1'b1;
        y.mem = '0;
        y.rsp_valid = 1'b1;
        y.rsp.fault = f;
        y.rsp.paddr = (f == FLT_NONE) ? pa : 32'h00000000;
        y.rsp.rights = (f == FLT_NONE) ? l : ACC_NONE;
        return y;
    endfunction

    // rights check, then flag update; locked write-back keeps the rmw atomic
    function automatic vat_st_t complete(vat_st_t x, logic [31:0] w, logic [31:0] pa, vat_acc_t l);
        vat_st_t y;
        logic [31:0] nw;
        y = x;
        nw = w;
        nw[ENT_ACC_BIT] = 1'b1;
        nw[ENT_ALT_BIT] = w[ENT_ALT_BIT] | x.req.write;
        if (denied(l, x.req.write))
        begin
            y = finish(x, pa, FLT_RIGHTS, l);
        end
        // R21 flag write-back
        else if (nw != w)
        begin
            y.mem.req = 1'b1;
            y.mem.we = 1'b1;
            y.mem.lock = 1'b1;
            y.mem.wdata = nw;
            y.wb_pa = pa;
            y.lev = l;
            y.state = ST_WB;
        end
        else
        begin
            y = finish(x, pa, FLT_NONE, l);
        end
        return y;
    endfunction

    // R17 region selector
    assign acc_ss = (req.kind == KIND_LOCATE) ? req.addr : region_ss[req.addr[31:30]];
    assign acc_idx = acc_ss[31:SS_IDX_LSB];

    always_comb
    begin
        n = s;
        n.rsp_valid = 1'b0;
        case (s.state)
            ST_IDLE:
            begin
                n.ready = 1'b1;
                if (req_valid && s.ready)
                begin
                    n.ready = 1'b0;
                    n.req = req;
                    n.ss = acc_ss;
                    n.lev = ACC_RW;
                    // R8 physical bypass
                    if (!virt_mode)
                    begin
                        n = finish(n, req.addr, FLT_NONE, ACC_RW);
                    end
                    else if (large_table)
                    begin
                        // R13 large length
                        if (acc_idx > LARGE_IDX_MAX)
                        begin
                            n = finish(n, 32'h00000000, FLT_SEG_LEN, ACC_NONE);
                        end
                        else
                        begin
                            n.mem = rd(desc_at(st_base, LARGE_PT_IDX) + DESC_CTRL_OFS, 1'b0);
                            n.state = ST_LPT;
                        end
                    end
                    // R11 small length
                    else if (acc_idx > SMALL_IDX_MAX)
                    begin
                        n = finish(n, 32'h00000000, FLT_SEG_LEN, ACC_NONE);
                    end
                    else
                    begin
                        // R12 small descriptor
                        n.daddr = desc_at(st_base, {6'h00, acc_idx});
                        n.mem = rd(n.daddr + DESC_CTRL_OFS, req.kind == KIND_XLATE);
                        n.state = ST_DESC;
                    end
                end
            end
            ST_LPT:
            begin
                if (mem_ack)
                begin
                    // R14 large page table
                    n.mem = rd(word_at(ent_base(mem_rdata), {22'h000000, s.ss[23:14]}), 1'b0);
                    n.state = ST_LPTE;
                end
            end
            ST_LPTE:
            begin
                if (mem_ack)
                begin
                    // R15 invalid table entry
                    if (!mem_rdata[ENT_VALID_BIT])
                    begin
                        n = finish(s, 32'h00000000, FLT_INV_PTE, ACC_NONE);
                    end
                    else
                    begin
                        // R16 large descriptor
                        n.daddr = desc_at(ent_base(mem_rdata), {24'h000000, s.ss[13:6]});
                        n.mem = rd(n.daddr + DESC_CTRL_OFS, s.req.kind == KIND_XLATE);
                        n.state = ST_DESC;
                    end
                end
            end
            ST_DESC:
            begin
                if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    if (s.req.kind == KIND_LOCATE)
                    begin
                        // R12 invalid descriptor
                        n = finish(s, s.daddr, mem_rdata[ENT_VALID_BIT] ? FLT_NONE : FLT_INV_SEG_DESC, ACC_RW);
                    end
                    // R18 invalid type
                    else if (mem_rdata[DESC_TYPE_LSB +: 3] == TYPE_INVALID)
                    begin
                        n = finish(s, 32'h00000000, FLT_INV_DESC, ACC_NONE);
                    end
                    // R19 region not valid
                    else if (!mem_rdata[ENT_VALID_BIT])
                    begin
                        n = finish(s, 32'h00000000, FLT_INV_STE, ACC_NONE);
                    end
                    else if (mem_rdata[DESC_TYPE_LSB +: 3] == TYPE_SIMPLE)
                    begin
                        // R20 simple length
                        if (s.req.addr[29:12] != 18'h00000)
                        begin
                            n = finish(s, 32'h00000000, FLT_SEG_LEN, ACC_NONE);
                        end
                        else
                        begin
                            // R22 simple address
                            n = complete(n, mem_rdata, ent_base(mem_rdata) | {20'h00000, s.req.addr[11:0]}, ACC_RW);
                        end
                    end
                    else if (mem_rdata[DESC_TYPE_LSB +: 3] == TYPE_PAGED)
                    begin
                        n.mem = rd(word_at(ent_base(mem_rdata), {22'h000000, s.req.addr[21:12]}), 1'b1);
                        n.state = ST_PTE;
                    end
                    else if (mem_rdata[DESC_TYPE_LSB +: 3] == TYPE_BIPAGED)
                    begin
                        n.mem = rd(word_at(ent_base(mem_rdata), {24'h000000, s.req.addr[29:22]}), 1'b0);
                        n.state = ST_PDE;
                    end
                    else
                    begin
                        // other types are unspecified; treated as invalid so nothing leaks
                        n = finish(s, 32'h00000000, FLT_INV_DESC, ACC_NONE);
                    end
                end
            end
            ST_PDE:
            begin
                if (mem_ack)
                begin
                    // R3 invalid entry ignored
                    if (!mem_rdata[ENT_VALID_BIT])
                    begin
                        n = finish(s, 32'h00000000, FLT_INV_PDE, ACC_NONE);
                    end
                    else if (denied(rights_lev(mem_rdata, s.req.user), s.req.write))
                    begin
                        n = finish(s, 32'h00000000, FLT_RIGHTS, ACC_NONE);
                    end
                    else
                    begin
                        // R2 directory base
                        // R10 one-page table
                        n.lev = rights_lev(mem_rdata, s.req.user);
                        n.mem = rd(word_at(ent_base(mem_rdata), {22'h000000, s.req.addr[21:12]}), 1'b1);
                        n.state = ST_PTE;
                    end
                end
            end
            ST_PTE:
            begin
                if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    if (!mem_rdata[ENT_VALID_BIT])
                    begin
                        n = finish(s, 32'h00000000, FLT_INV_PTE, ACC_NONE);
                    end
                    else
                    begin
                        // R6 table rights
                        // R9 translated address
                        n = complete(n, mem_rdata, ent_base(mem_rdata) | {20'h00000, s.req.addr[11:0]},
                            min_lev(s.lev, rights_lev(mem_rdata, s.req.user)));
                    end
                end
            end
            ST_WB:
            begin
                if (mem_ack)
                begin
                    n = finish(s, s.wb_pa, FLT_NONE, s.lev);
                end
            end
            default:
            begin
                n = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign req_ready = s.ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp = s.rsp;
    assign mem = s.mem;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_accept_virt;
        req_valid && req_ready && virt_mode;
    endsequence

    sequence seq_desc_ack;
        s.state == ST_DESC && mem_ack && s.req.kind == KIND_XLATE;
    endsequence

    sequence seq_pte_ack_valid;
        s.state == ST_PTE && mem_ack && mem_rdata[ENT_VALID_BIT];
    endsequence

    chk_phys_bypass: assert property ( // R8
        req_valid && req_ready && !virt_mode |=> rsp_valid && rsp.fault == FLT_NONE
            && rsp.paddr == $past(req.addr) && !mem.req)
        else $error("physical mode access was not passed straight through");

    chk_small_len: assert property ( // R11
        seq_accept_virt ##0 (!large_table && acc_idx > SMALL_IDX_MAX) |=> rsp_valid && rsp.fault == FLT_SEG_LEN)
        else $error("small table index above limit did not fault");

    chk_small_addr: assert property ( // R12
        seq_accept_virt ##0 (!large_table && acc_idx <= SMALL_IDX_MAX) |=> mem.req && !mem.we
            && mem.addr == $past(st_base) + ($past({6'h00, acc_idx}) << DESC_SHIFT) + DESC_CTRL_OFS)
        else $error("small table descriptor address wrong");

    chk_large_len: assert property ( // R13
        seq_accept_virt ##0 (large_table && acc_idx > LARGE_IDX_MAX) |=> rsp_valid && rsp.fault == FLT_SEG_LEN)
        else $error("large table index above limit did not fault");

    chk_large_pte: assert property ( // R14
        s.state == ST_LPT && mem_ack |=> s.state == ST_LPTE
            && mem.addr == ($past(mem_rdata) & BASE_MASK) + {20'h00000, s.ss[23:14], 2'h0})
        else $error("large table entry address wrong");

    chk_large_inv: assert property ( // R15
        s.state == ST_LPTE && mem_ack && !mem_rdata[ENT_VALID_BIT] |=> rsp_valid && rsp.fault == FLT_INV_PTE)
        else $error("invalid large table entry did not fault");

    chk_region_ste: assert property ( // R19
        seq_desc_ack ##0 (mem_rdata[DESC_TYPE_LSB +: 3] != TYPE_INVALID && !mem_rdata[ENT_VALID_BIT])
            |=> rsp_valid && rsp.fault == FLT_INV_STE)
        else $error("region descriptor with clear valid flag did not fault");

    chk_simple_len: assert property ( // R20
        seq_desc_ack ##0 (mem_rdata[DESC_TYPE_LSB +: 3] == TYPE_SIMPLE && mem_rdata[ENT_VALID_BIT]
            && s.req.addr[29:12] != 18'h00000) |=> rsp_valid && rsp.fault == FLT_SEG_LEN)
        else $error("simple region length fault missing");

    chk_user_rights: assert property ( // R4
        seq_pte_ack_valid ##0 (s.lev == ACC_RW && s.req.user && !mem_rdata[ENT_RIGHTS_LSB + 1])
            |=> rsp_valid && rsp.fault == FLT_RIGHTS)
        else $error("user access to no-access page was allowed");

    chk_sup_ro: assert property ( // R5
        seq_pte_ack_valid ##0 (s.lev == ACC_RW && !s.req.user && s.req.write
            && mem_rdata[ENT_RIGHTS_LSB +: 2] == RTS_SUP_RO) |=> rsp_valid && rsp.fault == FLT_RIGHTS)
        else $error("supervisor write to read-only page was allowed");

    // a read-only directory must cap a read-write page; writes already fault at the directory
    chk_min_rights: assert property ( // R7
        seq_pte_ack_valid ##0 (s.lev == ACC_RO && !s.req.write && mem_rdata[ENT_ACC_BIT])
            |=> rsp_valid && rsp.rights != ACC_RW)
        else $error("page rights exceeded the directory rights");

    chk_flag_wb: assert property ( // R21
        s.state == ST_WB |-> mem.req && mem.we && mem.lock && mem.wdata[ENT_ACC_BIT]
            && (mem.wdata[ENT_ALT_BIT] || !s.req.write))
        else $error("flag write-back malformed or not locked");

    chk_fault_clean: assert property ( // R23
        rsp_valid && rsp.fault != FLT_NONE |-> rsp.paddr == 32'h00000000 && !mem.req && !mem.lock)
        else $error("faulted access left an address or a memory request");
endmodule

// file: verif/vat_mem_model.sv
// memory model: word store answering the walker's memory port.
// assumes requests on mclk, held until mem_ack; unknown words read as ~addr.
`timescale 1ns/1ps
module vat_mem_model
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    input wire vat_pkg::vat_mem_req_t mem,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic lock_err
);
    import vat_pkg::*;
    logic [31:0] store [logic [31:0]];
    int wait_n;
    function automatic logic [31:0] peek(input logic [31:0] a);
        return store.exists(a) ? store[a] : ~a;
    endfunction
    task automatic poke(input logic [31:0] a, input logic [31:0] d);
        store[a] = d;
    endtask
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_ack <= 1'h0;
            mem_rdata <= 32'h0;
            wait_n <= 0;
            lock_err <= 1'h0;
        end
        else if (mem_ack)
        begin
            mem_ack <= 1'h0;
            // released bus must not keep old data
            mem_rdata <= ~mem_rdata;
            wait_n <= 0;
        end
        else if (mem.req && wait_n < (slow ? 3 : 0))
            wait_n <= wait_n + 1;
        else if (mem.req)
        begin
            mem_ack <= 1'h1;
            mem_rdata <= peek(mem.addr);
            if (mem.we)
            begin
                store[mem.addr] = mem.wdata;
                if (!mem.lock)
                    lock_err <= 1'h1;
            end
        end
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// file: verif/vat_walker_bench.sv
// self-checking bench for the translation walker with a memory model.
// assumes one 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module vat_walker_bench;
    import vat_pkg::*;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic virt_mode = 1'h1;
    logic large_table = 1'h0;
    logic slow = 1'h0;
    logic [31:0] st_base = 32'h00010000;
    logic [3:0][31:0] region_ss = {32'h00000100, 32'h000000c0, 32'h00000080, 32'h00000040};
    logic req_valid = 1'h0;
    vat_req_t req = '0;
    logic req_ready, rsp_valid, mem_ack, lock_err;
    logic [31:0] mem_rdata;
    vat_rsp_t rsp;
    vat_mem_req_t mem;
    vat_acc_t got_r;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    always #5 mclk = ~mclk;
    vat_walker DUT (.mclk(mclk), .rst_n(rst_n), .virt_mode(virt_mode), .large_table(large_table),
        .st_base(st_base), .region_ss(region_ss), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    vat_mem_model mm (.mclk(mclk), .rst_n(rst_n), .slow(slow), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .lock_err(lock_err));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request, bounded wait for its answer
    task automatic xl(input vat_kind_t k, input logic [31:0] a, input logic w, input logic u,
        input logic [31:0] epa, input vat_fault_t ef);
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        req_valid = 1'h1;
        req = '{kind: k, addr: a, write: w, user: u};
        @(negedge mclk);
        req_valid = 1'h0;
        while (rsp_valid !== 1'h1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, rsp_valid}, 32'h1);
        chk({31'h0, req_ready}, 32'h1);
        chk(rsp.paddr, epa);
        chk({29'h0, rsp.fault}, {29'h0, ef});
        got_r = rsp.rights;
        @(negedge mclk);
    endtask
    task automatic t_phys();
        virt_mode = 1'h0;
        xl(KIND_XLATE, 32'h12345678, 1'h1, 1'h1, 32'h12345678, FLT_NONE);
        virt_mode = 1'h1;
    endtask
    task automatic t_simple();
        mm.poke(32'h0001001c, 32'h00050021);
        xl(KIND_XLATE, 32'h00000abc, 1'h0, 1'h1, 32'h00050abc, FLT_NONE);
        chk(mm.peek(32'h0001001c), 32'h00050029);
        xl(KIND_XLATE, 32'h00000123, 1'h1, 1'h1, 32'h00050123, FLT_NONE);
        chk(mm.peek(32'h0001001c), 32'h00050039);
        xl(KIND_XLATE, 32'h20000000, 1'h0, 1'h1, 32'h0, FLT_SEG_LEN);
        xl(KIND_XLATE, 32'h00001000, 1'h0, 1'h0, 32'h0, FLT_SEG_LEN);
        mm.poke(32'h0001001c, 32'h00050020);
        xl(KIND_XLATE, 32'h00000010, 1'h0, 1'h0, 32'h0, FLT_INV_STE);
        mm.poke(32'h0001001c, 32'h00050001);
        xl(KIND_XLATE, 32'h00000010, 1'h0, 1'h0, 32'h0, FLT_INV_DESC);
    endtask
    // slow memory here, every rights code in both modes
    task automatic t_rights();
        vat_acc_t e;
        vat_fault_t f;
        slow = 1'h1;
        mm.poke(32'h0001002c, 32'h00060041);
        for (int r = 0; r < 4; r++)
            for (int u = 0; u < 2; u++)
                for (int w = 0; w < 2; w++)
                begin
                    mm.poke(32'h0006000c, 32'h00070019 | (32'(r) << 6));
                    e = u ? (r < 2 ? ACC_NONE : (r == 2 ? ACC_RO : ACC_RW)) : (r == 0 ? ACC_RO : ACC_RW);
                    f = (e == ACC_NONE || (w == 1 && e == ACC_RO)) ? FLT_RIGHTS : FLT_NONE;
                    xl(KIND_XLATE, 32'h40003123, 1'(w), 1'(u), f == FLT_NONE ? 32'h00070123 : 32'h0, f);
                    chk({30'h0, got_r}, {30'h0, f == FLT_NONE ? e : ACC_NONE});
                end
        slow = 1'h0;
    endtask
    task automatic t_bipaged();
        mm.poke(32'h0001003c, 32'h00080061);
        mm.poke(32'h00080004, 32'h00090099);
        mm.poke(32'h00090008, 32'h000a00d9);
        xl(KIND_XLATE, 32'h80402045, 1'h0, 1'h1, 32'h000a0045, FLT_NONE);
        chk({30'h0, got_r}, {30'h0, ACC_RO});
        xl(KIND_XLATE, 32'h80402045, 1'h1, 1'h1, 32'h0, FLT_RIGHTS);
        mm.poke(32'h00090008, 32'hfffffffe);
        xl(KIND_XLATE, 32'h80402045, 1'h0, 1'h0, 32'h0, FLT_INV_PTE);
        mm.poke(32'h00080004, 32'hfffffffe);
        xl(KIND_XLATE, 32'h80402045, 1'h0, 1'h0, 32'h0, FLT_INV_PDE);
    endtask
    task automatic t_locate();
        mm.poke(32'h00010ffc, 32'h00000001);
        xl(KIND_LOCATE, 32'h00003fc0, 1'h0, 1'h0, 32'h00010ff0, FLT_NONE);
        xl(KIND_LOCATE, 32'h00004000, 1'h0, 1'h0, 32'h0, FLT_SEG_LEN);
        mm.poke(32'h0001004c, 32'h0);
        xl(KIND_LOCATE, 32'h00000100, 1'h0, 1'h0, 32'h0, FLT_INV_SEG_DESC);
        large_table = 1'h1;
        mm.poke(32'h0001008c, 32'h000b0001);
        mm.poke(32'h000b0ffc, 32'h000c0001);
        mm.poke(32'h000c0ffc, 32'h00000001);
        xl(KIND_LOCATE, 32'h00ffffc0, 1'h0, 1'h0, 32'h000c0ff0, FLT_NONE);
        xl(KIND_LOCATE, 32'h01000000, 1'h0, 1'h0, 32'h0, FLT_SEG_LEN);
        mm.poke(32'h000b0000, 32'h000d0001);
        mm.poke(32'h000d001c, 32'h000e0039);
        xl(KIND_XLATE, 32'h00000055, 1'h0, 1'h0, 32'h000e0055, FLT_NONE);
        mm.poke(32'h000c0fec, 32'h0);
        xl(KIND_LOCATE, 32'h00ffff80, 1'h0, 1'h0, 32'h0, FLT_INV_SEG_DESC);
        mm.poke(32'h000b0004, 32'hfffffffe);
        xl(KIND_LOCATE, 32'h000040c0, 1'h0, 1'h0, 32'h0, FLT_INV_PTE);
        large_table = 1'h0;
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        rst_n = 1'h1;
        repeat (2) @(negedge mclk);
        t_phys();
        t_simple();
        t_rights();
        t_bipaged();
        t_locate();
        chk({31'h0, lock_err}, 32'h0);
        finish_test();
    end
    // hang guard, far above the expected run length
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end
endmodule
